// ---- src/ssu_core.sv ----
`timescale 1ns/1ps
module ssu_core
	import ssu_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial pins in
	input wire ssu_pins_in_type pins_in,
	// Serial pins out
	output ssu_pins_out_type pins_out,
	// Event
	output logic transfer_done_interrupt
);

	// ==========================================================
	// State
	typedef enum logic [1:0]
	{
		SSU_IDLE = 2'b00,
		SSU_LEAD = 2'b10,
		SSU_SHIFT = 2'b01,
		SSU_DONE = 2'b11
	} ssu_phase_type;

	typedef struct packed
	{
		logic [7:0] control;
		logic [7:0] shifter;
		logic [7:0] rx_data;
		logic done;
		logic write_collision_flag;
		logic ovf;
		logic status_seen;
		ssu_phase_type phase;
		logic [3:0] edges;
		logic sclk_lvl;
		logic sclk_prev;
		logic en_drop;
		logic mosi_bit;
		logic irq;
		logic [7:0] rd_q;
		ssu_pins_out_type pins;
	} ssu_state_type;

	ssu_state_type st_r;
	ssu_state_type st_nxt;

	logic wr_stb;
	logic rd_stb;
	logic [SSU_ADDR_W-1:0] reg_addr;
	logic [7:0] wr_data;
	logic half_tick;
	ssu_cfg_type cfg;

	// ==========================================================
	// Bus front end and divider
	ssu_ahb_slave u_bus
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.rd_data(st_r.rd_q)
	);

	ssu_rate_gen u_rate
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.run((st_r.phase == SSU_SHIFT || st_r.phase == SSU_DONE) && cfg.master),
		.rate(cfg.rate),
		.half_tick(half_tick)
	);

	// Decoded configuration
	assign cfg.enable = st_r.control[SSU_CR_UNIT_ENABLE];
	assign cfg.master = st_r.control[SSU_CR_MASTER];
	assign cfg.lsb_first = st_r.control[SSU_CR_BIT_ORDER];
	assign cfg.cpol = st_r.control[SSU_CR_CPOL];
	assign cfg.cpha = st_r.control[SSU_CR_CPHA];
	assign cfg.rate = st_r.control[SSU_CR_RATE_HI:SSU_CR_RATE_LO];

	// Outgoing bit, chosen by bit order
	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		out_bit = lsb ? sh[0] : sh[SSU_BITS-1];
	endfunction : out_bit

	// Shift in one sample at the end opposite the outgoing bit
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic lsb,
		input logic b);
		shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction : shift_in

	// ==========================================================
	// Next state
	always_comb
	begin
		logic busy;
		logic slave_sel;
		logic sclk_now;
		logic lead_edge;
		logic trail_edge;
		logic sample_edge;
		logic shift_edge;
		logic in_bit;
		logic clr_flags;
		logic ended;
		clr_flags = 1'b0;
		ended = 1'b0;
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		busy = (st_r.phase != SSU_IDLE);
		slave_sel = !cfg.master && cfg.enable && !pins_in.ss_n_in;

		// Edge finding: master uses its own clock, slave the pin
		sclk_now = cfg.master ? st_r.sclk_lvl : pins_in.sclk_in;
		if (cfg.master && st_r.phase == SSU_SHIFT && half_tick)
			sclk_now = !st_r.sclk_lvl;
		st_nxt.sclk_prev = sclk_now;
		// Leading edge leaves the idle level
		lead_edge = (sclk_now != st_r.sclk_prev) && (sclk_now != cfg.cpol);
		trail_edge = (sclk_now != st_r.sclk_prev) && (sclk_now == cfg.cpol);
		sample_edge = cfg.cpha ? trail_edge : lead_edge;
		shift_edge = cfg.cpha ? lead_edge : trail_edge;
		in_bit = cfg.master ? pins_in.miso_in : pins_in.mosi_in;

		// Clear sequence: status read arms, data access clears
		if (rd_stb && reg_addr == SSU_ADDR_STATUS)
			st_nxt.status_seen = 1'b1;
		if ((rd_stb || wr_stb) && reg_addr == SSU_ADDR_DATA && st_r.status_seen)
		begin
			clr_flags = 1'b1;
			st_nxt.status_seen = 1'b0;
		end
		if (clr_flags)
		begin
			st_nxt.done = 1'b0;
			st_nxt.write_collision_flag = 1'b0;
			st_nxt.ovf = 1'b0;
		end

		// A disable that arrives mid-transfer is held until the unit goes idle
		if (!busy && st_r.en_drop)
		begin
			st_nxt.control[SSU_CR_UNIT_ENABLE] = 1'b0;
			st_nxt.en_drop = 1'b0;
		end
		// Control write; a new enable setting only lands when idle
		if (wr_stb && reg_addr == SSU_ADDR_CONTROL)
		begin
			st_nxt.control = wr_data;
			st_nxt.en_drop = busy && !wr_data[SSU_CR_UNIT_ENABLE];
			if (busy)
				st_nxt.control[SSU_CR_UNIT_ENABLE] = st_r.control[SSU_CR_UNIT_ENABLE];
			if (wr_data[SSU_CR_MASTER])
				st_nxt.ovf = 1'b0;
		end

		// Data write: start, load, or collide
		if (wr_stb && reg_addr == SSU_ADDR_DATA)
		begin
			if (busy || (!cfg.master && !cfg.cpha && !pins_in.ss_n_in))
			begin
				st_nxt.write_collision_flag = 1'b1;
			end
			else
			begin
				st_nxt.shifter = wr_data;
				st_nxt.mosi_bit = out_bit(wr_data, cfg.lsb_first);
				if (cfg.master && cfg.enable)
				begin
					st_nxt.phase = SSU_SHIFT;
					st_nxt.edges = 4'h0;
				end
			end
		end

		// Slave: selection starts a byte; deselect abandons it
		if (!cfg.master)
		begin
			if (slave_sel && st_r.phase == SSU_IDLE)
			begin
				st_nxt.phase = SSU_SHIFT;
				st_nxt.edges = 4'h0;
			end
			if (!slave_sel && busy)
			begin
				st_nxt.phase = SSU_IDLE;
				st_nxt.edges = 4'h0;
			end
		end

		// Bit engine
		if (st_r.phase == SSU_SHIFT && (cfg.master || slave_sel))
		begin
			if (cfg.master)
				st_nxt.sclk_lvl = sclk_now;
			// Phase one drives its first bit on the first edge, others on shift edges
			if (shift_edge && (cfg.cpha || st_r.edges != 4'h0))
				st_nxt.mosi_bit = out_bit(st_r.shifter, cfg.lsb_first);
			if (sample_edge)
			begin
				st_nxt.shifter = shift_in(st_r.shifter, cfg.lsb_first, in_bit);
				st_nxt.edges = st_r.edges + 4'h1;
				if (st_r.edges + 4'h1 == SSU_LAST_BIT)
					ended = 1'b1;
			end
		end

		// Completion: master waits for the clock to return idle
		if (ended)
			st_nxt.phase = SSU_DONE;
		if (st_r.phase == SSU_DONE && cfg.master && half_tick)
			st_nxt.sclk_lvl = cfg.cpol; // closing edge a half period on
		if (st_r.phase == SSU_DONE)
		begin
			if (!cfg.master || st_r.sclk_lvl == cfg.cpol)
			begin
				st_nxt.rx_data = st_r.shifter;
				st_nxt.phase = cfg.master ? SSU_IDLE : SSU_LEAD;
				st_nxt.edges = 4'h0;
				if (!cfg.master && st_r.done)
					st_nxt.ovf = 1'b1;
				if (!st_r.done)
					st_nxt.irq = 1'b1;
				st_nxt.done = 1'b1;
			end
		end
		// Phase-zero slave drops to idle and starts the next byte a cycle later if still selected; phase one goes straight on while selected
		if (st_r.phase == SSU_LEAD && (pins_in.ss_n_in || cfg.cpha || !cfg.enable))
			st_nxt.phase = SSU_IDLE;
		if (st_r.phase == SSU_LEAD && !pins_in.ss_n_in && cfg.cpha && cfg.enable)
		begin
			st_nxt.phase = SSU_SHIFT;
			st_nxt.edges = 4'h0;
		end
		// Hold idle level while not transferring
		if (st_r.phase == SSU_IDLE && st_nxt.phase == SSU_IDLE)
			st_nxt.sclk_lvl = cfg.cpol;
		if (!cfg.enable)
			st_nxt.edges = 4'h0;
		if (cfg.master)
			st_nxt.ovf = 1'b0;

		// Read data, registered for the data phase
		st_nxt.rd_q = 8'h00;
		if (rd_stb)
		begin
			unique case (reg_addr)
				SSU_ADDR_STATUS: st_nxt.rd_q = {st_nxt.done, st_nxt.write_collision_flag,
					st_nxt.ovf & !cfg.master, 5'h00};
				SSU_ADDR_DATA: st_nxt.rd_q = st_r.rx_data;
				SSU_ADDR_CONTROL: st_nxt.rd_q = st_r.control;
				default: st_nxt.rd_q = 8'h00;
			endcase
		end

		// Pins
		st_nxt.pins.sclk_out = st_nxt.sclk_lvl;
		st_nxt.pins.sclk_oe = cfg.master && cfg.enable;
		st_nxt.pins.mosi_out = st_nxt.mosi_bit;
		st_nxt.pins.mosi_oe = cfg.master && cfg.enable;
		st_nxt.pins.miso_out = st_nxt.mosi_bit;
		st_nxt.pins.miso_oe = !cfg.master && cfg.enable;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= '0;
			st_r.control <= SSU_CONTROL_RST;
			st_r.rx_data <= SSU_DATA_RST;
			st_r.phase <= SSU_IDLE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign pins_out = st_r.pins;
	assign transfer_done_interrupt = st_r.irq;

endmodule : ssu_core

// ---- src/ssu_pkg.sv ----
package ssu_pkg;

	// ==========================================================
	// Register map (printed offsets are not word aligned: indexes)
	localparam logic [7:0] SSU_IDX_STATUS = 8'h28;
	localparam logic [7:0] SSU_IDX_DATA = 8'h29;
	localparam logic [7:0] SSU_IDX_CONTROL = 8'h2A;
	localparam int SSU_ADDR_W = 10;
	localparam logic [9:0] SSU_ADDR_STATUS = {SSU_IDX_STATUS, 2'b00};
	localparam logic [9:0] SSU_ADDR_DATA = {SSU_IDX_DATA, 2'b00};
	localparam logic [9:0] SSU_ADDR_CONTROL = {SSU_IDX_CONTROL, 2'b00};

	// ==========================================================
	// Reset values
	localparam logic [7:0] SSU_CONTROL_RST = 8'h04;
	localparam logic [7:0] SSU_DATA_RST = 8'h00;

	// ==========================================================
	// Control field positions
	localparam int SSU_CR_MODE_FAULT_DIS = 7;
	localparam int SSU_CR_UNIT_ENABLE = 6;
	localparam int SSU_CR_BIT_ORDER = 5;
	localparam int SSU_CR_MASTER = 4;
	localparam int SSU_CR_CPOL = 3;
	localparam int SSU_CR_CPHA = 2;
	localparam int SSU_CR_RATE_HI = 1;
	localparam int SSU_CR_RATE_LO = 0;

	// Status field positions
	localparam int SSU_SR_DONE = 7;
	localparam int SSU_SR_WRITE_COLLISION_FLAG = 6;
	localparam int SSU_SR_OVF = 5;

	// ==========================================================
	// Transfer constants
	localparam int SSU_BITS = 8;
	localparam logic [3:0] SSU_LAST_BIT = 4'h8;
	// Half serial period in system clocks for divide 4, 8, 16, 64
	localparam logic [5:0] SSU_HALF_DIV4 = 6'h02;
	localparam logic [5:0] SSU_HALF_DIV8 = 6'h04;
	localparam logic [5:0] SSU_HALF_DIV16 = 6'h08;
	localparam logic [5:0] SSU_HALF_DIV64 = 6'h20;

	// ==========================================================
	// Carriers
	typedef struct packed
	{
		logic enable;
		logic master;
		logic lsb_first;
		logic cpol;
		logic cpha;
		logic [1:0] rate;
	} ssu_cfg_type;

	typedef struct packed
	{
		logic sclk_in;
		logic mosi_in;
		logic miso_in;
		logic ss_n_in;
	} ssu_pins_in_type;

	typedef struct packed
	{
		logic sclk_out;
		logic sclk_oe;
		logic mosi_out;
		logic mosi_oe;
		logic miso_out;
		logic miso_oe;
	} ssu_pins_out_type;

endpackage : ssu_pkg

// ---- src/ssu_rate_gen.sv ----
`timescale 1ns/1ps
// Master bit-rate divider: one-cycle tick per half serial period
module ssu_rate_gen
	import ssu_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic run,
	input wire logic [1:0] rate,
	// Output
	output logic half_tick
);

	typedef struct packed
	{
		logic [5:0] cnt;
		logic tick;
	} ssu_rg_state_type;

	ssu_rg_state_type st_r;
	ssu_rg_state_type st_nxt;

	// ==========================================================
	// Divider select
	function automatic logic [5:0] half_of(input logic [1:0] sel);
		unique case (sel)
			2'b00: half_of = SSU_HALF_DIV4;
			2'b01: half_of = SSU_HALF_DIV8;
			2'b10: half_of = SSU_HALF_DIV16;
			2'b11: half_of = SSU_HALF_DIV64;
		endcase
	endfunction : half_of

	// Count restarts with each transfer so the first half period is full
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!run)
		begin
			st_nxt.cnt = 6'h00;
		end
		else if (st_r.cnt == half_of(rate) - 6'h01)
		begin
			st_nxt.cnt = 6'h00;
			st_nxt.tick = 1'b1;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 6'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign half_tick = st_r.tick;

endmodule : ssu_rate_gen

// ---- src/ssu_ahb_slave.sv ----
`timescale 1ns/1ps
// AHB-Lite front end: turns bus transfers into one-cycle register strobes
module ssu_ahb_slave
	import ssu_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Register side
	output logic wr_stb,
	output logic rd_stb,
	output logic [SSU_ADDR_W-1:0] reg_addr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);

	typedef struct packed
	{
		logic pend_wr;
		logic [SSU_ADDR_W-1:0] addr;
	} ssu_ahb_state_type;

	ssu_ahb_state_type st_r;
	ssu_ahb_state_type st_nxt;
	logic take;

	// ==========================================================
	// Address phase; every access is zero wait state
	assign take = hsel && hready && htrans[1];

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pend_wr = take && hwrite;
		if (take)
			st_nxt.addr = haddr[SSU_ADDR_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Reads are strobed in the address phase so data is ready next cycle
	assign rd_stb = take && !hwrite;
	assign wr_stb = st_r.pend_wr;
	assign reg_addr = rd_stb ? haddr[SSU_ADDR_W-1:0] : st_r.addr;
	assign wr_data = hwdata[7:0];
	assign hrdata = {24'h000000, rd_data};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

endmodule : ssu_ahb_slave

// ---- test/ssu_properties.sv ----
`timescale 1ns/1ps
// ====
// Port checker for the serial core
module ssu_properties
	import ssu_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Pins and event
	input wire ssu_pins_out_type pins_out,
	input wire logic transfer_done_interrupt
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic [4:0] edges_r;
	logic [4:0] edges_nxt;
	logic sclk_d_r;
	logic oe_d_r;
	// Count driven clock edges; an edge on the oe turn-on cycle is a level set, not a pulse
	always_comb
	begin
		edges_nxt = edges_r;
		if (transfer_done_interrupt)
			edges_nxt = 5'h00;
		else if (pins_out.sclk_oe && oe_d_r && (pins_out.sclk_out != sclk_d_r))
			edges_nxt = edges_r + 5'h01;
	end
	// Helper registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			edges_r <= 5'h00;
			sclk_d_r <= 1'b0;
			oe_d_r <= 1'b0;
		end
		else
		begin
			edges_r <= edges_nxt;
			sclk_d_r <= pins_out.sclk_out;
			oe_d_r <= pins_out.sclk_oe;
		end
	end
	property p_done_edges;
		transfer_done_interrupt && pins_out.sclk_oe |-> edges_r == 5'h10;
	endproperty
	a_done_edges: assert property (p_done_edges)
		else $error("clock edge count wrong at done");
	property p_irq_pulse;
		transfer_done_interrupt |=> !transfer_done_interrupt;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("done pulse longer than one cycle");
	property p_miso_alone;
		pins_out.miso_oe |-> !pins_out.sclk_oe && !pins_out.mosi_oe;
	endproperty
	a_miso_alone: assert property (p_miso_alone)
		else $error("slave and master drivers on together");
	property p_mosi_with_sclk;
		pins_out.sclk_oe == pins_out.mosi_oe;
	endproperty
	a_mosi_with_sclk: assert property (p_mosi_with_sclk)
		else $error("master data and clock drivers differ");
	property p_half_min;
		pins_out.sclk_oe && $past(pins_out.sclk_oe) && $changed(pins_out.sclk_out)
			|=> $stable(pins_out.sclk_out);
	endproperty
	a_half_min: assert property (p_half_min)
		else $error("serial clock half period below two cycles");
	property p_idle_done;
		transfer_done_interrupt && pins_out.sclk_oe |-> $stable(pins_out.sclk_out);
	endproperty
	a_idle_done: assert property (p_idle_done)
		else $error("serial clock moving at done");
	property p_byte_lane;
		hrdata[31:8] == 24'h000000;
	endproperty
	a_byte_lane: assert property (p_byte_lane)
		else $error("read data outside low byte");
	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus answer not ready or not okay");
endmodule : ssu_properties

bind ssu_core ssu_properties u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .pins_out(pins_out),
	.transfer_done_interrupt(transfer_done_interrupt));

// ---- test/ssu_peer.sv ----
`timescale 1ns/1ps
// ====
// Far-side peripheral for master transfers
module ssu_peer
	import ssu_pkg::*;
(
	// Serial lines
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// Setup
	input wire ssu_cfg_type cfg,
	input wire logic sel,
	input wire logic [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sr;
	logic first;
	initial miso = 1'b1;
	// Load the reply byte when selected
	always @(posedge sel)
	begin
		sr = tx;
		first = 1'b1;
		rx = 8'h00;
	end
	// Sample on one edge, shift on the other; phase one keeps bit one past the first edge
	always @(sclk)
	begin
		if (sel && (sclk ^ cfg.cpol ^ cfg.cpha))
			rx = cfg.lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (sel && first && cfg.cpha)
			first = 1'b0;
		else if (sel)
			sr = cfg.lsb_first ? sr >> 1 : sr << 1;
	end
	// Released line flips its level on each sel, sr or cfg change
	always @(sel or sr or cfg)
	begin
		if (sel)
			miso = cfg.lsb_first ? sr[0] : sr[7];
		else
			miso = ~miso;
	end
endmodule : ssu_peer

// ---- test/tb.sv ----
`timescale 1ns/1ps
// ====
// Serial core bench
module tb
	import ssu_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, irq;
	logic sclk_i = 1'b0, mosi_i = 1'b0, ss_n_i = 1'b1, miso_p, sel = 1'b0, sclk_last;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [7:0] rd, prx, ptx = 8'h00;
	logic [5:0] half;
	ssu_cfg_type cfg = '0;
	ssu_pins_in_type pins_in;
	ssu_pins_out_type pins_out;
	int mismatches, samples_checked, nedge, bad_gap, gap, nirq;
	assign pins_in = {sclk_i, mosi_i, miso_p, ss_n_i};
	ssu_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .pins_in(pins_in), .pins_out(pins_out),
		.transfer_done_interrupt(irq));
	ssu_peer peer (.sclk(pins_out.sclk_out), .mosi(pins_out.mosi_out), .miso(miso_p),
		.cfg(cfg), .sel(sel), .tx(ptx), .rx(prx));
	always #50 hclk = ~hclk;
	// Serial clock spacing and done pulse counts
	always @(posedge hclk)
	begin
		gap = gap + 1;
		if (pins_out.sclk_oe === 1'b1 && pins_out.sclk_out !== sclk_last)
		begin
			if (nedge > 0 && gap != half)
				bad_gap = bad_gap + 1;
			nedge = nedge + 1;
			gap = 0;
		end
		sclk_last = pins_out.sclk_out;
		if (irq === 1'b1)
			nirq = nirq + 1;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Bounded wait for ready; a hang ends the run
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			mismatches++;
			stop_test();
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] wd,
		output logic [7:0] rv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h000000, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wait_rdy();
		rv = hrdata[7:0];
	endtask : bus
	task automatic wait_done;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
			n++;
		end
		while (rd[7] !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			mismatches++;
			stop_test();
		end
	endtask : wait_done
	// Slave-side byte at clock/8, mode zero; the line is changed after the frame
	task automatic sbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			mosi_i <= b[i];
			repeat (4) @(posedge hclk);
			sclk_i <= 1'b1;
			repeat (4) @(posedge hclk);
			sclk_i <= 1'b0;
		end
		repeat (4) @(posedge hclk);
		mosi_i <= ~b[0];
	endtask : sbyte
	task automatic t_reset;
		bus(1'b0, SSU_ADDR_CONTROL, 8'h00, rd);
		check("control reset", 8'h04, rd);
		bus(1'b0, SSU_ADDR_DATA, 8'h00, rd);
		check("data reset", 8'h00, rd);
		bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
		check("flags reset", 3'h0, rd[7:5]);
		bus(1'b1, 10'h0AC, 8'hFF, rd);
		bus(1'b0, 10'h0AC, 8'h00, rd);
		check("unmapped", 8'h00, rd);
		check("clock drive off", 1'b0, pins_out.sclk_oe);
		$display("test reset done");
	endtask : t_reset
	// Master transfer; extra 1 adds a colliding write, 2 a disable in flight
	task automatic xfer(input logic [7:0] lo, input logic [7:0] tx, input logic [7:0] px,
		input int extra);
		cfg = {2'b11, lo[5], lo[3], lo[2], lo[1:0]};
		half = (lo[1:0] == 2'h3) ? 6'h20 : (6'h02 << lo[1:0]);
		bus(1'b1, SSU_ADDR_CONTROL, 8'h90 | lo, rd);
		bus(1'b1, SSU_ADDR_CONTROL, 8'hD0 | lo, rd);
		repeat (2) @(negedge hclk);
		nedge = 0;
		bad_gap = 0;
		nirq = 0;
		ptx = px;
		sel = 1'b1;
		bus(1'b1, SSU_ADDR_DATA, tx, rd);
		if (extra == 1)
			bus(1'b1, SSU_ADDR_DATA, 8'hFF, rd);
		if (extra == 2)
			bus(1'b1, SSU_ADDR_CONTROL, 8'h90 | lo, rd);
		wait_done();
		check("status", (extra == 1) ? 8'hC0 : 8'h80, rd);
		check("clock edges", 16, nedge);
		check("half period misses", 0, bad_gap);
		check("done pulses", 1, nirq);
		check("idle clock", lo[3], pins_out.sclk_out);
		check("peer byte", tx, prx);
		bus(1'b0, SSU_ADDR_DATA, 8'h00, rd);
		check("received", px, rd);
		bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
		check("status cleared", 8'h00, rd);
		check("enable after transfer", (extra != 2), pins_out.sclk_oe);
		sel = 1'b0;
		$display("test transfer %h done", lo);
	endtask : xfer
	task automatic t_slave;
		bus(1'b1, SSU_ADDR_CONTROL, 8'h80, rd);
		bus(1'b1, SSU_ADDR_CONTROL, 8'hC0, rd);
		repeat (2) @(posedge hclk);
		check("slave out drive", 1'b1, pins_out.miso_oe);
		check("slave clock drive", 1'b0, pins_out.sclk_oe);
		sbyte(8'h5A);
		bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
		check("deselected done", 1'b0, rd[7]);
		ss_n_i <= 1'b0;
		bus(1'b1, SSU_ADDR_DATA, 8'h11, rd);
		sbyte(8'h5A);
		ss_n_i <= 1'b1;
		repeat (4) @(posedge hclk);
		ss_n_i <= 1'b0;
		sbyte(8'h3C);
		ss_n_i <= 1'b1;
		bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
		check("slave status", 8'hE0, rd);
		bus(1'b0, SSU_ADDR_DATA, 8'h00, rd);
		check("slave received", 8'h3C, rd);
		bus(1'b0, SSU_ADDR_STATUS, 8'h00, rd);
		check("slave cleared", 8'h00, rd);
		bus(1'b1, SSU_ADDR_CONTROL, 8'h80, rd);
		repeat (2) @(posedge hclk);
		check("idle out drive", 1'b0, pins_out.miso_oe);
		$display("test slave done");
	endtask : t_slave
	// Main sequence
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		xfer(8'h00, 8'h1D, 8'hB2, 0);
		xfer(8'h2D, 8'h6E, 8'h39, 0);
		xfer(8'h0A, 8'h47, 8'hE1, 1);
		xfer(8'h27, 8'h9C, 8'h53, 2);
		t_slave();
		stop_test();
	end
endmodule : tb
